// *** test/rxp_far_end.sv ***
`default_nettype none
// remote hub on the backplane: its clock, its symbols and the pull-ups
module rxp_far_end import rxp_pkg::*; (
	// frame control from the bench
	input wire logic run,
	input wire logic [SYM_W-1:0] sym,
	// device pin drives
	input wire logic [SYM_W-1:0] dev_sym_oe,
	input wire logic dev_clk_oe,
	// resolved wire levels
	output logic [SYM_W-1:0] sym_wire,
	output logic clk_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hub_clk = 1'b1; // parks high on the pull-up
	// 160 ns link clock, only inside a frame so nothing ticks between frames
	initial begin
		forever begin
			#80 hub_clk = run ? ~hub_clk : 1'b1;
		end
	end
	// open drain: pull-up wins unless somebody pulls low
	assign clk_wire = hub_clk & ~dev_clk_oe;
	// symbols released to the pull-ups outside a frame
	assign sym_wire = (run ? sym : {SYM_W{1'b1}}) & ~dev_sym_oe;
endmodule : rxp_far_end
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
// compare a design value against its expectation
`define CHK(g, e) check(16'(g), 16'(e))
module testbench import rxp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus and observed signals
	logic mclk = 1'b0, rst_b = 1'b0, run = 1'b1, link_clk;
	logic port_rx_active = 1'b0, local_collision = 1'b0, sourcing = 1'b0;
	logic [SYM_W-1:0] tx_sym = '0, far_sym = 5'h0C, sym_w, sym_o, sym_oe, rx_sym;
	logic tx_valid = 1'b0, tx_ready, rx_valid, rx_ready = 1'b1, rx_overrun, stack_collision;
	logic local_act_n, stack_act_n, clk_o, clk_oe, col_o, col_oe, col_w;
	logic [PEER_N-1:0] peer_n = '1;
	logic [HUB_N-1:0] hub_n = '1;
	logic stack_col_in_n = 1'b1;
	logic [EN_N-1:0] strap = 3'b011, en_i, en_o, en_oe; // collision enable strapped low
	int failures = 0, compares = 0, n;
	// one common reference clock
	initial begin
		forever begin
			#2 mclk = ~mclk;
		end
	end
	// strap pulls until the pins are driven
	assign en_i = (en_oe & en_o) | (~en_oe & strap);
	// shared collision line with its pull-up
	assign col_w = ~(col_oe & ~col_o);
	rxp_far_end u_far (.run(run), .sym(far_sym), .dev_sym_oe(sym_oe), .dev_clk_oe(clk_oe),
		.sym_wire(sym_w), .clk_wire(link_clk));
	rxp_port dut (.mclk(mclk), .rst_b(rst_b), .backplane_symbol_clock(link_clk),
		.port_rx_active(port_rx_active), .local_collision(local_collision),
		.sourcing(sourcing), .tx_sym(tx_sym), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_sym(rx_sym), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
		.stack_collision(stack_collision), .local_activity_out_n(local_act_n),
		.peer_activity_in_n(peer_n), .stack_activity_out_n(stack_act_n),
		.hub_activity_in_n(hub_n), .inter_rep_symbol_i(sym_w), .inter_rep_symbol_o(sym_o),
		.inter_rep_symbol_oe(sym_oe), .bp_clk_o(clk_o), .bp_clk_oe(clk_oe),
		.shared_collision_n_i(col_w), .shared_collision_n_o(col_o),
		.shared_collision_n_oe(col_oe), .stack_collision_in_n(stack_col_in_n),
		.xcvr_en_i(en_i), .xcvr_en_o(en_o), .xcvr_en_oe(en_oe));
	// count and report one comparison
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check
	// idle cycles on the falling edge
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask : cyc
	// strap phase then idle enable levels per polarity
	task automatic t_strap();
		`CHK(en_oe, 3'b000);
		cyc(STRAP_CYC + 4);
		`CHK(en_oe, 3'b111);
		`CHK(en_o, 3'b011);
		$display("test strap done");
	endtask : t_strap
	// own and peer activity reach the outputs
	task automatic t_activity();
		port_rx_active = 1'b1;
		#1 `CHK(local_act_n, 1'b0);
		`CHK(stack_act_n, 1'b0);
		cyc(3);
		`CHK(en_o[EN_TX], 1'b0);
		port_rx_active = 1'b0;
		#1 `CHK(local_act_n, 1'b1);
		cyc(3);
		`CHK(stack_act_n, 1'b1);
		peer_n[0] = 1'b0;
		cyc(3);
		`CHK(stack_act_n, 1'b0);
		`CHK(en_o[EN_TX], 1'b0);
		peer_n = '1;
		cyc(4);
		`CHK(en_o[EN_TX], 1'b1);
		$display("test activity done");
	endtask : t_activity
	// hub activity opens the receivers unless a local device is busy
	task automatic t_hub();
		hub_n[HUB_N-1] = 1'b0;
		cyc(4);
		`CHK(en_o[EN_RX], 1'b0);
		port_rx_active = 1'b1;
		cyc(3);
		`CHK(en_o[EN_RX], 1'b1);
		port_rx_active = 1'b0;
		hub_n = '1;
		cyc(4);
		$display("test hub done");
	endtask : t_hub
	// local pull of the shared line and the stack collision input
	task automatic t_collision();
		local_collision = 1'b1;
		cyc(1);
		`CHK(col_oe, 1'b1);
		`CHK(col_o, 1'b0);
		cyc(5);
		`CHK(en_o[EN_COL], 1'b1);
		`CHK(stack_collision, 1'b1);
		local_collision = 1'b0;
		cyc(8);
		`CHK(col_oe, 1'b0);
		`CHK(stack_collision, 1'b0);
		stack_col_in_n = 1'b0;
		cyc(6);
		`CHK(stack_collision, 1'b1);
		stack_col_in_n = 1'b1;
		cyc(6);
		$display("test collision done");
	endtask : t_collision
	// offer one word until it is taken; valid stays up for the caller to drop
	task automatic push(input logic [SYM_W-1:0] w);
		tx_sym = w;
		tx_valid = 1'b1;
		n = 0;
		// ready is looked at mid-cycle, where it is settled
		while (tx_ready !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		`CHK(tx_ready, 1'b1);
		cyc(1);
	endtask : push
	// fill the buffer, refuse a third word, then source it out in order
	task automatic t_transmit();
		run = 1'b0;
		cyc(80);
		push(5'h0A);
		push(5'h13);
		tx_sym = 5'h1E;
		tx_valid = 1'b1;
		cyc(3);
		`CHK(tx_ready, 1'b0);
		tx_valid = 1'b0;
		sourcing = 1'b1;
		for (n = 0; n < 300 && sym_oe === '0; n++) cyc(1);
		`CHK(sym_oe, 5'h15);
		for (n = 0; n < 60 && sym_oe === ~5'h0A; n++) cyc(1);
		`CHK(sym_oe, 5'h0C);
		// measure one full period of the sourced clock: low half then high half
		for (n = 0; n < 40 && clk_oe !== 1'b0; n++) cyc(1);
		for (n = 0; n < 40 && clk_oe !== 1'b1; n++) cyc(1);
		for (n = 0; n < 40 && clk_oe === 1'b1; n++) cyc(1);
		while (n < 40 && clk_oe !== 1'b1) begin
			cyc(1);
			n++;
		end
		`CHK(n, 2 * BP_HALF_CYC);
		sourcing = 1'b0;
		cyc(4);
		`CHK(sym_oe, 5'h00);
		`CHK(clk_oe, 1'b0);
		`CHK(sym_o, 5'h00);
		`CHK(clk_o, 1'b0);
		$display("test transmit done");
	endtask : t_transmit
	// receive from a remote hub, then stall until a word is dropped
	task automatic t_receive();
		run = 1'b1;
		hub_n[0] = 1'b0;
		for (n = 0; n < 400 && !(rx_valid === 1'b1 && rx_sym === 5'h0C); n++) cyc(1);
		`CHK(rx_sym, 5'h0C);
		rx_ready = 1'b0;
		for (n = 0; n < 600 && rx_overrun !== 1'b1; n++) cyc(1);
		`CHK(rx_overrun, 1'b1);
		`CHK(rx_valid, 1'b1);
		rx_ready = 1'b1;
		hub_n = '1;
		run = 1'b0;
		cyc(8);
		$display("test receive done");
	endtask : t_receive
	// verdict and end of run
	task automatic final_report();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// main sequence
	initial begin
		cyc(2);
		rst_b = 1'b1;
		t_strap();
		t_activity();
		t_hub();
		t_collision();
		t_transmit();
		t_receive();
		final_report();
	end
	// hang guard, well beyond the expected run time
	initial begin
		#60000;
		failures++;
		final_report();
	end
endmodule : testbench
`default_nettype wire

// *** verilog/rxp_pkg.sv ***
`default_nettype none
// shared constants and carriers of the expansion port
package rxp_pkg;
	localparam int SYM_W = 5; // symbol width on the bus
	localparam int PEER_N = 5; // other devices on the local bus
	localparam int HUB_N = 7; // other hubs on the backplane
	localparam int EN_N = 3; // transceiver enable pins
	// enable pin indices
	localparam int EN_RX = 0;
	localparam int EN_TX = 1;
	localparam int EN_COL = 2;
	// clock periods in picoseconds
	localparam int MCLK_PS = 4000;
	localparam int BP_CLK_PS = 40000;
	// half period of the sourced backplane clock, in mclk cycles
	localparam int BP_HALF_CYC = BP_CLK_PS / (2 * MCLK_PS);
	// settle time before enable straps are caught, rounded up
	localparam int STRAP_NS = 100;
	localparam int STRAP_CYC = (STRAP_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
	localparam int CNT_W = 8; // width of the small counters
	// open-drain or tristate pin drive
	typedef struct packed {
		logic o;
		logic oe;
	} rxp_drv_t;
	// activity summary of the local bus and the backplane
	typedef struct packed {
		logic own;
		logic peer;
		logic hub;
	} rxp_act_t;
	// strap phase then normal running
	typedef enum logic {RXP_STRAP, RXP_RUN} rxp_state_t;
endpackage : rxp_pkg
`default_nettype wire

// *** verilog/rxp_port.sv ***
`default_nettype none
// two-entry crossing buffer, gray pointers
module rxp_afifo #(
	parameter int W = 5,
	parameter int AW = 1
) (
	// write side
	input wire logic wclk,
	input wire logic wrst_b,
	input wire logic [W-1:0] wdata,
	input wire logic wvalid,
	output logic wready,
	// read side
	input wire logic rclk,
	input wire logic rrst_b,
	output logic [W-1:0] rdata,
	output logic rvalid,
	input wire logic rready
);
	logic [W-1:0] mem_r [2**AW]; // storage
	logic [AW:0] wbin_r, rbin_r, wgray_r, rgray_r; // pointers
	logic [AW:0] rg_q1, rg_q2, wg_q1, wg_q2; // synchronisers
	logic [AW:0] rbin_w, wbin_w; // far pointers in binary
	// gray to binary
	function automatic logic [AW:0] g2b(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : g2b
	assign rbin_w = g2b(rg_q2);
	assign wbin_w = g2b(wg_q2);
	// full when wrap bits differ and addresses match
	assign wready = !((wbin_r[AW] != rbin_w[AW]) && (wbin_r[AW-1:0] == rbin_w[AW-1:0]));
	assign rvalid = (rbin_r != wbin_w);
	assign rdata = mem_r[rbin_r[AW-1:0]];
	// write side pointer and storage
	always_ff @(posedge wclk or negedge wrst_b) begin
		if (!wrst_b) begin
			wbin_r <= '0;
			wgray_r <= '0;
		end else if (wvalid && wready) begin
			wbin_r <= wbin_r + 1'b1;
			wgray_r <= (wbin_r + 1'b1) ^ ((wbin_r + 1'b1) >> 1);
		end
	end
	always_ff @(posedge wclk) begin
		if (wvalid && wready) begin
			mem_r[wbin_r[AW-1:0]] <= wdata;
		end
	end
	// read pointer brought into write side
	always_ff @(posedge wclk or negedge wrst_b) begin
		if (!wrst_b) begin
			rg_q1 <= '0;
			rg_q2 <= '0;
		end else begin
			rg_q1 <= rgray_r;
			rg_q2 <= rg_q1;
		end
	end
	// read side pointer
	always_ff @(posedge rclk or negedge rrst_b) begin
		if (!rrst_b) begin
			rbin_r <= '0;
			rgray_r <= '0;
		end else if (rvalid && rready) begin
			rbin_r <= rbin_r + 1'b1;
			rgray_r <= (rbin_r + 1'b1) ^ ((rbin_r + 1'b1) >> 1);
		end
	end
	// write pointer brought into read side
	always_ff @(posedge rclk or negedge rrst_b) begin
		if (!rrst_b) begin
			wg_q1 <= '0;
			wg_q2 <= '0;
		end else begin
			wg_q1 <= wgray_r;
			wg_q2 <= wg_q1;
		end
	end
endmodule : rxp_afifo

// expansion port of one repeater device
module rxp_port import rxp_pkg::*; (
	// clocks and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic backplane_symbol_clock,
	// repeater core side
	input wire logic port_rx_active,
	input wire logic local_collision,
	input wire logic sourcing,
	input wire logic [SYM_W-1:0] tx_sym,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [SYM_W-1:0] rx_sym,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_overrun,
	output logic stack_collision,
	// activity lines
	output logic local_activity_out_n,
	input wire logic [PEER_N-1:0] peer_activity_in_n,
	output logic stack_activity_out_n,
	input wire logic [HUB_N-1:0] hub_activity_in_n,
	// symbol lines, open drain
	input wire logic [SYM_W-1:0] inter_rep_symbol_i,
	output logic [SYM_W-1:0] inter_rep_symbol_o,
	output logic [SYM_W-1:0] inter_rep_symbol_oe,
	// backplane clock pin, open drain
	output logic bp_clk_o,
	output logic bp_clk_oe,
	// collision lines
	input wire logic shared_collision_n_i,
	output logic shared_collision_n_o,
	output logic shared_collision_n_oe,
	input wire logic stack_collision_in_n,
	// transceiver enables: rx, tx, collision
	input wire logic [EN_N-1:0] xcvr_en_i,
	output logic [EN_N-1:0] xcvr_en_o,
	output logic [EN_N-1:0] xcvr_en_oe
);
	// pin synchronisers
	logic [PEER_N-1:0] peer_q1, peer_q2;
	logic [HUB_N-1:0] hub_q1, hub_q2;
	logic col_q1, col_q2, stk_q1, stk_q2;
	logic [EN_N-1:0] en_q1, en_q2;
	rxp_act_t act; // activity summary
	logic rx_en_act; // receive enable, combinational
	logic tx_en_r, col_en_r, col_drv_r, stk_col_r; // clocked controls
	logic [EN_N-1:0] en_act, pol_hi_r; // enable levels, strap polarity
	rxp_state_t st_r, st_nxt;
	logic [CNT_W-1:0] strap_cnt_r, div_cnt_r;
	logic bp_clk_r; // sourced clock level
	rxp_drv_t col_drv;

	// rising-edge samplers for activity, collision and straps
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			peer_q1 <= '1;
			peer_q2 <= '1;
			hub_q1 <= '1;
			hub_q2 <= '1;
			col_q1 <= 1'b1;
			col_q2 <= 1'b1;
			en_q1 <= '1;
			en_q2 <= '1;
		end else begin
			peer_q1 <= peer_activity_in_n;
			peer_q2 <= peer_q1;
			hub_q1 <= hub_activity_in_n;
			hub_q2 <= hub_q1;
			col_q1 <= shared_collision_n_i;
			col_q2 <= col_q1;
			en_q1 <= xcvr_en_i;
			en_q2 <= en_q1;
		end
	end
	// stack collision caught on the falling edge first
	always_ff @(negedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stk_q1 <= 1'b1;
		end else begin
			stk_q1 <= stack_collision_in_n;
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stk_q2 <= 1'b1;
		end else begin
			stk_q2 <= stk_q1;
		end
	end

	// activity decode; the out lines follow the core with no clock
	assign act.own = port_rx_active;
	assign act.peer = |(~peer_q2);
	assign act.hub = |(~hub_q2);
	assign local_activity_out_n = !act.own;
	assign stack_activity_out_n = !(act.own || act.peer);
	// take the backplane only when nothing local is active
	assign rx_en_act = act.hub && !(act.own || act.peer);

	// clocked enables and collision drive
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_en_r <= 1'b0;
			col_en_r <= 1'b0;
			col_drv_r <= 1'b0;
			stk_col_r <= 1'b0;
		end else begin
			tx_en_r <= act.own || act.peer;
			col_en_r <= !col_q2;
			col_drv_r <= local_collision;
			stk_col_r <= !stk_q2 || !col_q2;
		end
	end
	assign stack_collision = stk_col_r;
	// open drain: only ever pulls low
	assign col_drv.o = 1'b0;
	assign col_drv.oe = col_drv_r;
	assign shared_collision_n_o = col_drv.o;
	assign shared_collision_n_oe = col_drv.oe;

	// strap phase: pins released so a pull-down can be seen
	assign st_nxt = (st_r == RXP_STRAP && strap_cnt_r == CNT_W'(STRAP_CYC)) ? RXP_RUN : st_r;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= RXP_STRAP;
			strap_cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			if (st_r == RXP_STRAP) begin
				strap_cnt_r <= strap_cnt_r + 1'b1;
			end
		end
	end
	assign en_act[EN_RX] = rx_en_act;
	assign en_act[EN_TX] = tx_en_r;
	assign en_act[EN_COL] = col_en_r;
	// per pin polarity catch and drive
	for (genvar i = 0; i < EN_N; i++) begin : g_en
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				pol_hi_r[i] <= 1'b0;
			end else if (st_r == RXP_STRAP && st_nxt == RXP_RUN) begin
				pol_hi_r[i] <= !en_q2[i];
			end
		end
		assign xcvr_en_o[i] = pol_hi_r[i] ? en_act[i] : !en_act[i];
		assign xcvr_en_oe[i] = (st_r == RXP_RUN);
	end

	// backplane clock source, divided from mclk
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_r <= '0;
			bp_clk_r <= 1'b1;
		end else begin
			case (sourcing)
				1'b1: begin
					if (div_cnt_r == CNT_W'(BP_HALF_CYC - 1)) begin
						div_cnt_r <= '0;
						bp_clk_r <= !bp_clk_r;
					end else begin
						div_cnt_r <= div_cnt_r + 1'b1;
					end
				end
				default: begin
					// parked high, so the pull-up owns the line
					div_cnt_r <= '0;
					bp_clk_r <= 1'b1;
				end
			endcase
		end
	end
	assign bp_clk_o = 1'b0;
	assign bp_clk_oe = sourcing && !bp_clk_r;

	// link side, clocked by the backplane clock
	logic src_l1, src_l2, hub_l1, hub_l2; // level crossings
	logic [SYM_W-1:0] sym_q1, sym_q2, sym_low_r;
	logic [SYM_W-1:0] tx_rdata, rx_wdata;
	logic tx_rvalid, tx_rready, rx_wvalid, rx_wready;
	logic ovr_tgl_r, ovr_m1, ovr_m2, ovr_m3;
	always_ff @(posedge backplane_symbol_clock or negedge rst_b) begin
		if (!rst_b) begin
			src_l1 <= 1'b0;
			src_l2 <= 1'b0;
			hub_l1 <= 1'b0;
			hub_l2 <= 1'b0;
			sym_q1 <= '1;
			sym_q2 <= '1;
		end else begin
			src_l1 <= sourcing;
			src_l2 <= src_l1;
			hub_l1 <= rx_en_act;
			hub_l2 <= hub_l1;
			sym_q1 <= inter_rep_symbol_i;
			sym_q2 <= sym_q1;
		end
	end
	// one symbol a link edge; an empty buffer sends all ones
	assign tx_rready = src_l2;
	always_ff @(posedge backplane_symbol_clock or negedge rst_b) begin
		if (!rst_b) begin
			sym_low_r <= '0;
		end else begin
			sym_low_r <= (tx_rvalid && tx_rready) ? ~tx_rdata : '0;
		end
	end
	// gated by the core level, so a stopped clock cannot hold the lines
	assign inter_rep_symbol_o = '0;
	assign inter_rep_symbol_oe = sym_low_r & {SYM_W{sourcing}};
	// receive: the link cannot stall, a full buffer drops the word
	assign rx_wdata = sym_q2;
	assign rx_wvalid = hub_l2 && !src_l2;
	always_ff @(posedge backplane_symbol_clock or negedge rst_b) begin
		if (!rst_b) begin
			ovr_tgl_r <= 1'b0;
		end else if (rx_wvalid && !rx_wready) begin
			ovr_tgl_r <= !ovr_tgl_r;
		end
	end
	// overrun toggle back into mclk, one pulse per drop
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ovr_m1 <= 1'b0;
			ovr_m2 <= 1'b0;
			ovr_m3 <= 1'b0;
		end else begin
			ovr_m1 <= ovr_tgl_r;
			ovr_m2 <= ovr_m1;
			ovr_m3 <= ovr_m2;
		end
	end
	assign rx_overrun = ovr_m2 ^ ovr_m3;

	// transmit buffer: stalls the core when two words wait
	rxp_afifo #(.W(SYM_W), .AW(1)) u_tx_buf (
		.wclk(mclk), .wrst_b(rst_b), .wdata(tx_sym), .wvalid(tx_valid),
		.wready(tx_ready), .rclk(backplane_symbol_clock), .rrst_b(rst_b),
		.rdata(tx_rdata), .rvalid(tx_rvalid), .rready(tx_rready)
	);
	// receive buffer toward the core
	rxp_afifo #(.W(SYM_W), .AW(1)) u_rx_buf (
		.wclk(backplane_symbol_clock), .wrst_b(rst_b), .wdata(rx_wdata),
		.wvalid(rx_wvalid), .wready(rx_wready), .rclk(mclk), .rrst_b(rst_b),
		.rdata(rx_sym), .rvalid(rx_valid), .rready(rx_ready)
	);

	// checks
	property p_lact;
		@(posedge mclk) disable iff (!rst_b) local_activity_out_n == !port_rx_active;
	endproperty
	a_lact: assert property (p_lact) else $error("local activity wrong");
	property p_peer;
		@(posedge mclk) disable iff (!rst_b)
			(!peer_activity_in_n[0]) [*3] |-> !stack_activity_out_n;
	endproperty
	a_peer: assert property (p_peer) else $error("peer activity lost");
	property p_sact;
		@(posedge mclk) disable iff (!rst_b) port_rx_active |-> !stack_activity_out_n;
	endproperty
	a_sact: assert property (p_sact) else $error("stack activity missing");
	property p_hub;
		@(posedge mclk) disable iff (!rst_b)
			(!hub_activity_in_n[0]) [*3] ##0 !port_rx_active ##0 !act.peer |-> rx_en_act;
	endproperty
	a_hub: assert property (p_hub) else $error("hub activity not seen");
	property p_rxen;
		@(posedge mclk) disable iff (!rst_b) port_rx_active |-> !rx_en_act;
	endproperty
	a_rxen: assert property (p_rxen) else $error("rx enable during local rx");
	property p_pol;
		@(posedge mclk) disable iff (!rst_b) st_r == RXP_RUN |->
			xcvr_en_oe[EN_TX] && xcvr_en_o[EN_TX] == (pol_hi_r[EN_TX] ~^ tx_en_r);
	endproperty
	a_pol: assert property (p_pol) else $error("enable polarity wrong");
	property p_txen;
		@(posedge mclk) disable iff (!rst_b) port_rx_active |=> tx_en_r;
	endproperty
	a_txen: assert property (p_txen) else $error("tx enable late");
	property p_clk;
		@(posedge mclk) disable iff (!rst_b) $rose(sourcing) ##1 sourcing [*5] |-> bp_clk_oe;
	endproperty
	a_clk: assert property (p_clk) else $error("clock not sourced");
	property p_col;
		@(posedge mclk) disable iff (!rst_b)
			local_collision |=> shared_collision_n_oe && !shared_collision_n_o;
	endproperty
	a_col: assert property (p_col) else $error("collision not driven");
	property p_stk;
		@(posedge mclk) disable iff (!rst_b) (!stack_collision_in_n) [*4] |=> stack_collision;
	endproperty
	a_stk: assert property (p_stk) else $error("stack collision lost");
	property p_colen;
		@(posedge mclk) disable iff (!rst_b) (!shared_collision_n_i) [*3] |=> col_en_r;
	endproperty
	a_colen: assert property (p_colen) else $error("collision enable late");
	property p_rel;
		@(posedge mclk) disable iff (!rst_b)
			!sourcing |-> !bp_clk_oe && inter_rep_symbol_oe == '0;
	endproperty
	a_rel: assert property (p_rel) else $error("lines not released");
	property p_sym;
		@(posedge backplane_symbol_clock) disable iff (!rst_b)
			tx_rvalid && tx_rready |=> sym_low_r == ~$past(tx_rdata);
	endproperty
	a_sym: assert property (p_sym) else $error("symbol not sent");
endmodule : rxp_port
`default_nettype wire

// *** verilog/rxp_top_note.sv ***
`default_nettype none
`default_nettype wire
